// file: pkg/drc_pkg.sv
// package for the dram cycle controller: timing counts, commands, pin carrier
// assumes a 100 MHz system clock
package drc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // pulse widths and delays in ns; refresh period in ms, power-up pause in us, rows and init cycles as counts
  localparam int unsigned ROW_ACTIVE_NS = 150;
  localparam int unsigned COL_ACTIVE_NS = 75;
  localparam int unsigned ROW_PRECHARGE_TIME_NS = 100;
  localparam int unsigned ROW_TO_COLUMN_DELAY_NS = 25;
  localparam int unsigned ACCESS_FROM_COLUMN_STROBE_NS = 75;
  localparam int unsigned COLUMN_BEFORE_ROW_SETUP_NS = 30;
  localparam int unsigned COL_PRECHARGE_NS = 60;
  localparam int unsigned REFRESH_PERIOD_MS = 4;
  localparam int unsigned REFRESH_ROWS = 256;
  localparam int unsigned POWERUP_PAUSE_US = 100;
  localparam int unsigned INIT_CYCLES = 8;
  // cycle counts: least times round up
  localparam int unsigned ROW_ACTIVE_CYC = (ROW_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned COL_ACTIVE_CYC = (COL_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRECHARGE_CYC =
    (ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RCD_CYC = (ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_CYC =
    (ACCESS_FROM_COLUMN_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
  localparam int unsigned CBR_SETUP_CYC =
    (COLUMN_BEFORE_ROW_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned COL_PRE_CYC = (COL_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // refresh interval per row: longest time rounds down
  localparam int unsigned REFRESH_INTERVAL_CYC =
    (REFRESH_PERIOD_MS * 1000000) / (REFRESH_ROWS * CLK_PERIOD_NS);
  localparam int unsigned POWERUP_CYC = (POWERUP_PAUSE_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned ADDR_W = 9;

  typedef enum logic [1:0] {
    DRC_OP_READ,
    DRC_OP_WRITE,
    DRC_OP_RMW
  } drc_op_t;

  // pins toward the memory
  typedef struct packed {
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_strobe_n;
    logic [ADDR_W-1:0] addr;
    logic data_in;
  } drc_pins_t;
endpackage

// file: hw/drc_ctrl.sv
// controller driving a 256K x 1 multiplexed-address dynamic ram
// assumes data_out pin arrives asynchronously; strobes drive the memory directly
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - hold strobes low for minimum active widths
// - keep row strobe high for precharge time
// - read keeps write strobe high throughout
// - data valid before later write/column fall
// - refresh every row within 4 ms
// - row-only cycle refreshes given row
// - column-before-row uses internal refresh counter
// - hidden refresh keeps column low, reads; not done here, refresh uses column-before-row cycles
// - page mode: row low, column cycles
// - nibble mode toggles column for bits
// - row half then column half on pins
// - 100 us pause then eight row cycles
module drc_ctrl
  import drc_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
  parameter int unsigned REFRESH_CYCLES = REFRESH_INTERVAL_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic req_valid,
  output logic req_ready,
  input wire drc_op_t req_op,
  input wire logic [17:0] req_addr,
  input wire logic req_wdata,
  input wire logic [2:0] req_burst,
  output logic rsp_valid,
  output logic [3:0] rsp_rdata,
  output logic init_done,
  output drc_pins_t pins,
  input wire logic mem_data_out
);

  typedef enum logic [3:0] {
    ST_PWRUP, ST_IDLE, ST_PRE, ST_ROW, ST_COL, ST_ACC, ST_CPRE,
    ST_CBR_SETUP, ST_CBR_ROW
  } drc_state_t;

  drc_state_t state_q;
  logic [16:0] cnt_q;
  logic [11:0] ref_cnt_q;
  logic ref_pend_q;
  logic [3:0] init_left_q;
  logic init_done_q;
  drc_op_t op_q;
  logic [17:0] addr_q;
  logic wdata_q;
  logic [2:0] burst_q;
  logic [2:0] beat_q;
  logic [3:0] rdata_q;
  logic rsp_q;
  logic dout_s1_q;
  logic dout_s2_q;
  logic ref_only_q;
  logic [7:0] ref_row_q;
  logic row_n_q;
  logic col_n_q;
  logic we_n_q;
  logic [ADDR_W-1:0] addr_pin_q;
  logic din_q;

  assign req_ready = (state_q == ST_IDLE) && init_done_q && !ref_pend_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign init_done = init_done_q;
  assign pins = '{row_strobe_n: row_n_q, col_strobe_n: col_n_q, write_strobe_n: we_n_q,
                  addr: addr_pin_q, data_in: din_q};

  // pin synchroniser
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dout_s1_q <= 1'b0;
      dout_s2_q <= 1'b0;
    end else begin
      dout_s1_q <= mem_data_out;
      dout_s2_q <= dout_s1_q;
    end
  end

  // refresh pacing, one row per interval
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ref_cnt_q <= '0;
      ref_pend_q <= 1'b0;
    end else begin
      if (ref_cnt_q == 12'(REFRESH_CYCLES - 1)) begin
        ref_cnt_q <= '0;
        ref_pend_q <= 1'b1;
      end else begin
        ref_cnt_q <= ref_cnt_q + 12'h001;
        // burst column precharge shares this state; only a counter refresh retires the request
        if (state_q == ST_CBR_ROW && ref_only_q && cnt_q == '0) begin
          ref_pend_q <= 1'b0;
        end
      end
    end
  end

  // main cycle sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_PWRUP;
      cnt_q <= 17'(POWERUP_CYCLES);
      init_left_q <= 4'(INIT_CYCLES);
      init_done_q <= 1'b0;
      op_q <= DRC_OP_READ;
      addr_q <= '0;
      wdata_q <= 1'b0;
      burst_q <= '0;
      beat_q <= '0;
      rdata_q <= '0;
      rsp_q <= 1'b0;
      ref_only_q <= 1'b0;
      ref_row_q <= '0;
      row_n_q <= 1'b1;
      col_n_q <= 1'b1;
      we_n_q <= 1'b1;
      addr_pin_q <= '0;
      din_q <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      if (cnt_q != '0) begin
        cnt_q <= cnt_q - 17'h00001;
      end
      unique case (state_q)
        ST_PWRUP: if (cnt_q == '0) begin
          // first row cycle must already be a row-only init cycle
          state_q <= ST_IDLE;
          cnt_q <= 17'(PRECHARGE_CYC);
        end
        ST_IDLE: begin
          if (!init_done_q) begin
            // row-only init cycle on the next refresh row
            ref_only_q <= 1'b1;
            addr_pin_q <= {1'b0, ref_row_q};
            state_q <= ST_PRE;
          end else if (ref_pend_q) begin
            col_n_q <= 1'b0;
            state_q <= ST_CBR_SETUP;
            cnt_q <= 17'(CBR_SETUP_CYC);
          end else if (req_valid) begin
            op_q <= req_op;
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            burst_q <= (req_burst > 3'h3) ? 3'h3 : req_burst;
            beat_q <= '0;
            ref_only_q <= 1'b0;
            addr_pin_q <= req_addr[17:9];
            state_q <= ST_PRE;
          end
        end
        ST_PRE: if (cnt_q == '0) begin
          row_n_q <= 1'b0;
          state_q <= ST_ROW;
          cnt_q <= 17'(ref_only_q ? ROW_ACTIVE_CYC : RCD_CYC);
        end
        ST_ROW: if (cnt_q == '0) begin
          if (ref_only_q) begin
            row_n_q <= 1'b1;
            state_q <= ST_CPRE;
            cnt_q <= 17'(PRECHARGE_CYC);
            ref_row_q <= ref_row_q + 8'h01;
            if (!init_done_q) begin
              init_left_q <= init_left_q - 4'h1;
            end
          end else begin
            addr_pin_q <= addr_q[8:0];
            we_n_q <= (op_q == DRC_OP_WRITE) ? 1'b0 : 1'b1;
            din_q <= wdata_q;
            state_q <= ST_COL;
          end
        end
        ST_COL: begin
          col_n_q <= 1'b0;
          state_q <= ST_ACC;
          cnt_q <= 17'(ACCESS_CYC);
        end
        ST_ACC: if (cnt_q == '0) begin
          if (op_q != DRC_OP_WRITE) begin
            // sample after access time from column strobe fall
            rdata_q[beat_q[1:0]] <= dout_s2_q;
          end
          if (op_q == DRC_OP_RMW && we_n_q) begin
            we_n_q <= 1'b0;
            cnt_q <= 17'(COL_ACTIVE_CYC);
          end else begin
            col_n_q <= 1'b1;
            we_n_q <= 1'b1;
            if (beat_q == burst_q) begin
              rsp_q <= 1'b1;
              row_n_q <= 1'b1;
              state_q <= ST_CPRE;
              cnt_q <= 17'(PRECHARGE_CYC);
            end else begin
              beat_q <= beat_q + 3'h1;
              we_n_q <= (op_q == DRC_OP_WRITE) ? 1'b0 : 1'b1;
              state_q <= ST_CBR_ROW;
              ref_only_q <= 1'b0;
              cnt_q <= 17'(COL_PRE_CYC);
            end
          end
        end
        ST_CPRE: if (cnt_q == '0) begin
          col_n_q <= 1'b1;
          state_q <= ST_IDLE;
          if (init_left_q == 4'h0) begin
            init_done_q <= 1'b1;
          end
        end
        ST_CBR_SETUP: if (cnt_q == '0) begin
          row_n_q <= 1'b0;
          state_q <= ST_CBR_ROW;
          ref_only_q <= 1'b1;
          cnt_q <= 17'(ROW_ACTIVE_CYC);
        end
        ST_CBR_ROW: if (cnt_q == '0) begin
          if (ref_only_q) begin
            // end counter refresh cycle; test cycle re-arm not used
            row_n_q <= 1'b1;
            col_n_q <= 1'b1;
            ref_only_q <= 1'b0;
            state_q <= ST_CPRE;
            cnt_q <= 17'(PRECHARGE_CYC);
          end else begin
            state_q <= ST_COL; // nibble/page next beat
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // precharge before any row strobe fall
  row_precharge_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(row_n_q) |-> row_n_q [*8]) else $error("precharge too short");
  row_width_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(row_n_q) |-> !row_n_q [*8]) else $error("row pulse too short");
  read_we_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (op_q == DRC_OP_READ && state_q == ST_ACC) |-> we_n_q) else $error("read with write");
  early_write_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == ST_COL && op_q == DRC_OP_WRITE) |-> !we_n_q) else $error("write late");
  din_stable_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!col_n_q && !we_n_q) |-> $stable(din_q)) else $error("data moved");
  cbr_setup_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == ST_CBR_SETUP) |-> (!col_n_q && row_n_q)) else $error("cbr order");
  addr_mux_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_q == ST_COL) |-> addr_pin_q == addr_q[8:0]) else $error("column addr");
  ready_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    req_ready |-> (init_left_q == 4'h0 && row_n_q && col_n_q)) else $error("ready early");
  cv_read_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    rsp_q && op_q == DRC_OP_READ);
  cv_rmw_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    rsp_q && op_q == DRC_OP_RMW);
  cv_refresh_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    state_q == ST_CBR_SETUP);
endmodule
`default_nettype wire

// file: verif/drc_mem_model.sv
// behavioural 256K x 1 dram: multiplexed address, nibble access, cbr counter
// assumes strobes come from the controller under test; counts timing slips
`timescale 1ns/10ps
`default_nettype none
module drc_mem_model
  import drc_pkg::*;
#(
  parameter real PAUSE_NS = 200.0
) (
  input wire drc_pins_t pins,
  input wire logic slow,
  output logic dq,
  output int viol,
  output int n_ref
);
  logic mem [0:262143];
  logic [8:0] row_q;
  logic [8:0] col_q;
  logic [7:0] cnt_q = 8'h00;
  logic open_q = 1'b0;
  logic first_q = 1'b0;
  logic rd_q = 1'b0;
  int seq = 0;
  int n_init = 0;
  realtime t_rf = 0;
  realtime t_rr = 0;
  realtime t_cf = 0;
  wire ras_n = pins.row_strobe_n;
  wire cas_n = pins.col_strobe_n;
  wire we_n = pins.write_strobe_n;
  initial begin
    dq = 1'b0;
    viol = 0;
    n_ref = 0;
  end
  always @(negedge ras_n) begin
    if ($realtime - t_rr < ROW_PRECHARGE_TIME_NS || $realtime < PAUSE_NS) viol++;
    t_rf = $realtime;
    n_init++;
    if (!cas_n) begin
      if ($realtime - t_cf < COLUMN_BEFORE_ROW_SETUP_NS) viol++;
      cnt_q++;
      n_ref++;
      open_q = 1'b0;
    end else begin
      row_q = pins.addr;
      open_q = 1'b1;
      first_q = 1'b1;
    end
  end
  always @(posedge ras_n) begin
    // the first rise comes out of reset, with no fall before it
    if (n_init > 0 && $realtime - t_rf < ROW_ACTIVE_NS) viol++;
    t_rr = $realtime;
    open_q = 1'b0;
  end
  always @(negedge cas_n) begin
    t_cf = $realtime;
    if (!ras_n && open_q) begin
      if (first_q) begin
        col_q = pins.addr;
        if (n_init < 9) viol++;
      end else begin
        {row_q[8], col_q[8]} = {row_q[8], col_q[8]} + 2'h1;
      end
      first_q = 1'b0;
      rd_q = mem[{row_q, col_q}];
      if (!we_n) begin
        mem[{row_q, col_q}] = pins.data_in;
      end else begin
        seq++;
        fork
          begin
            automatic int s = seq;
            #(slow ? ACCESS_FROM_COLUMN_STROBE_NS : 20);
            if (s == seq && !cas_n) dq = rd_q;
          end
        join_none
      end
    end
  end
  // late fall of write: old data stays driven while the cell takes the new bit
  always @(negedge we_n) begin
    if (!cas_n && !ras_n && open_q && !first_q) mem[{row_q, col_q}] = pins.data_in;
  end
  // released output shows the inverse of its last value
  always @(posedge cas_n) begin
    seq++;
    dq = ~dq;
  end
endmodule
`default_nettype wire

// file: verif/drc_ctrl_tb.sv
// self-checking bench for the dram cycle controller
// assumes the behavioural memory model and shortened pause and refresh counts
`timescale 1ns/10ps
`default_nettype none
module drc_ctrl_tb
  import drc_pkg::*;
;
  localparam int unsigned PU = 20;
  localparam int unsigned RF = 200;
  typedef struct {drc_op_t op; logic [17:0] a; logic wd; logic [2:0] bu; logic [3:0] ex;} drc_row_t;
  drc_row_t rows [13] = '{
    '{DRC_OP_WRITE, 18'h0B43C, 1'b1, 3'h0, 4'h0}, '{DRC_OP_WRITE, 18'h0B53C, 1'b0, 3'h0, 4'h0},
    '{DRC_OP_WRITE, 18'h2B43C, 1'b1, 3'h0, 4'h0}, '{DRC_OP_WRITE, 18'h2B53C, 1'b1, 3'h0, 4'h0},
    '{DRC_OP_READ, 18'h0B43C, 1'b0, 3'h0, 4'h1}, '{DRC_OP_READ, 18'h2B43C, 1'b0, 3'h3, 4'h7},
    '{DRC_OP_RMW, 18'h0B53C, 1'b1, 3'h0, 4'h0}, '{DRC_OP_READ, 18'h0B53C, 1'b0, 3'h0, 4'h1},
    '{DRC_OP_READ, 18'h2B53C, 1'b0, 3'h7, 4'hF}, '{DRC_OP_WRITE, 18'h0B43C, 1'b0, 3'h3, 4'h0},
    '{DRC_OP_READ, 18'h0B53C, 1'b0, 3'h3, 4'h0}, '{DRC_OP_WRITE, 18'h3FFFF, 1'b1, 3'h0, 4'h0},
    '{DRC_OP_READ, 18'h3FFFF, 1'b0, 3'h0, 4'h1}};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready;
  drc_op_t req_op = DRC_OP_READ;
  logic [17:0] req_addr = 18'h00000;
  logic req_wdata = 1'b0;
  logic [2:0] req_burst = 3'h0;
  logic rsp_valid;
  logic [3:0] rsp_rdata;
  logic init_done;
  drc_pins_t pins;
  logic dq;
  logic slow = 1'b1;
  int viol;
  int n_ref;
  int miscompares = 0;
  int n_compared = 0;
  int r0;
  always #5 clk_sys = ~clk_sys;
  drc_ctrl #(.POWERUP_CYCLES(PU), .REFRESH_CYCLES(RF)) u_drc_ctrl (.clk_sys(clk_sys),
    .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_burst(req_burst), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .init_done(init_done), .pins(pins), .mem_data_out(dq));
  drc_mem_model #(.PAUSE_NS(PU * 10.0)) u_drc_mem_model (.pins(pins), .slow(slow), .dq(dq),
    .viol(viol), .n_ref(n_ref));
  task automatic finish_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp4(input logic [3:0] got, input logic [3:0] ex);
    n_compared++;
    if (got !== ex) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, ex);
    end
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    int k;
    k = 0;
    while (s !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      k++;
      if (k > lim) begin
        miscompares++;
        finish_test();
      end
    end
  endtask
  // request held until taken; the edge after ready is the taking edge
  task automatic run(input drc_row_t r);
    logic [3:0] m;
    m = 4'hF >> (3 - ((r.bu > 3'h3) ? 3 : r.bu));
    req_op = r.op;
    req_addr = r.a;
    req_wdata = r.wd;
    req_burst = r.bu;
    req_valid = 1'b1;
    wait_hi(req_ready, 2000);
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    wait_hi(rsp_valid, 400);
    if (r.op != DRC_OP_WRITE) cmp4(rsp_rdata & m, r.ex);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    cmp4({pins.row_strobe_n, pins.col_strobe_n, req_ready, rsp_valid}, 4'hC);
    rstn = 1'b1;
    wait_hi(init_done, 2000);
    cmp4({3'h0, n_ref != 0}, 4'h0);
    for (int i = 0; i < 13; i++) begin
      slow = i[0];
      run(rows[i]);
    end
    r0 = n_ref;
    repeat (5 * RF) @(posedge clk_sys);
    #1;
    cmp4({3'h0, n_ref - r0 >= 4}, 4'h1);
    run('{DRC_OP_READ, 18'h2B43C, 1'b0, 3'h0, 4'h0});
    // mid-run reset while the row is precharging, then a fresh init
    rstn = 1'b0;
    @(posedge clk_sys);
    #1;
    cmp4({pins.row_strobe_n, pins.col_strobe_n, req_ready, init_done}, 4'hC);
    rstn = 1'b1;
    wait_hi(init_done, 2000);
    run('{DRC_OP_READ, 18'h3FFFF, 1'b0, 3'h0, 4'h1});
    cmp4({3'h0, viol != 0}, 4'h0);
    finish_test();
  end
endmodule
`default_nettype wire
